// ==== ls_serdes_lane_config_regs.sv ====
// Per-lane drive, rate, polarity and equalizer register bank
`default_nettype none

module ls_serdes_lane_config_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Management register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Lane selection and override controls
  input wire logic [3:0] lane_config_write_mask_i,
  input wire logic refclk_rate_select_bit_i,
  input wire logic [3:0] pll_multiplier_code_i,
  // Hardware-chosen rates and multiplier
  input wire logic [3:0][1:0] auto_tx_rate_i,
  input wire logic [3:0][1:0] auto_rx_rate_i,
  input wire logic [3:0] auto_pll_multiplier_code_i,
  // Power-down controls
  input wire logic channel_power_down_n_i,
  input wire logic global_power_down_i,
  // Per-lane settings to the analog lanes
  output logic [3:0][2:0] lane_output_amplitude_sel_o,
  output logic [3:0] lane_signal_loss_detect_en_o,
  output logic [3:0] tx_path_lane_enable_o,
  output logic [3:0][1:0] tx_path_lane_rate_o,
  output logic [3:0][3:0] lane_deemphasis_code_o,
  output logic [3:0] rx_path_lane_enable_o,
  output logic [3:0][1:0] rx_path_lane_rate_o,
  output logic [3:0] rx_output_polarity_swap_o,
  output logic [3:0] tx_input_polarity_swap_o,
  output logic [3:0][3:0] lane_equalizer_code_o,
  output logic [3:0] lane_equalizer_code_rsvd_o,
  // PLL multiplier result
  output logic [3:0] pll_multiplier_code_o,
  output logic [7:0] pll_multiplier_factor_x2_o,
  output logic pll_multiplier_code_rsvd_o
);

  ls_lane_cfg_pkg::lane_words_t drive_q;
  ls_lane_cfg_pkg::lane_words_t poleq_q;
  logic lanes_on;
  logic override;
  logic hit_drive;
  logic hit_poleq;
  logic [1:0] rd_lane;

  pll_mpy_if mpy ();

  // Address decode and power gating shared by every lane
  assign hit_drive = (reg_addr_i == ls_lane_cfg_pkg::ADDR_DRIVE_RATE);
  assign hit_poleq = (reg_addr_i == ls_lane_cfg_pkg::ADDR_POL_EQ);
  assign lanes_on = channel_power_down_n_i & ~global_power_down_i;
  assign override = refclk_rate_select_bit_i;
  assign rd_lane = ls_lane_cfg_pkg::one_hot_index(lane_config_write_mask_i);

  // Drive/rate copies; a lane whose mask bit is clear keeps its old word
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        drive_q[l] <= ls_lane_cfg_pkg::RST_DRIVE_RATE;
      end else if (reg_wr_i && hit_drive && lane_config_write_mask_i[l]) begin
        drive_q[l] <= reg_wdata_i;
      end
    end
  end

  // Polarity/eq copies; the reserved low byte is kept exactly as written
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        poleq_q[l] <= ls_lane_cfg_pkg::RST_POL_EQ;
      end else if (reg_wr_i && hit_poleq && lane_config_write_mask_i[l]) begin
        poleq_q[l] <= reg_wdata_i;
      end
    end
  end

  // Read strobe echoed one cycle later, whatever the address
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // Read data; a mixed mask reads zero rather than a blend of lanes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      if (!ls_lane_cfg_pkg::is_one_hot(lane_config_write_mask_i)) begin
        reg_rdata_o <= 16'h0000;
      end else if (hit_drive) begin
        reg_rdata_o <= drive_q[rd_lane];
      end else if (hit_poleq) begin
        reg_rdata_o <= poleq_q[rd_lane];
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

  // Output amplitude, registered so the analog side sees clean levels
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        lane_output_amplitude_sel_o[l] <=
          ls_lane_cfg_pkg::RST_DRIVE_RATE[ls_lane_cfg_pkg::AMP_MSB:ls_lane_cfg_pkg::AMP_LSB];
      end else begin
        lane_output_amplitude_sel_o[l] <=
          drive_q[l][ls_lane_cfg_pkg::AMP_MSB:ls_lane_cfg_pkg::AMP_LSB];
      end
    end
  end

  // Signal-loss detector enable
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        lane_signal_loss_detect_en_o[l] <=
          ls_lane_cfg_pkg::RST_DRIVE_RATE[ls_lane_cfg_pkg::LOS_EN_BIT];
      end else begin
        lane_signal_loss_detect_en_o[l] <= drive_q[l][ls_lane_cfg_pkg::LOS_EN_BIT];
      end
    end
  end

  // De-emphasis code, passed through untouched
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        lane_deemphasis_code_o[l] <=
          ls_lane_cfg_pkg::RST_DRIVE_RATE[ls_lane_cfg_pkg::DE_MSB:ls_lane_cfg_pkg::DE_LSB];
      end else begin
        lane_deemphasis_code_o[l] <=
          drive_q[l][ls_lane_cfg_pkg::DE_MSB:ls_lane_cfg_pkg::DE_LSB];
      end
    end
  end

  // Transmit lane enable; power-down wins over the stored bit
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        tx_path_lane_enable_o[l] <= 1'b0;
      end else begin
        tx_path_lane_enable_o[l] <= drive_q[l][ls_lane_cfg_pkg::TX_EN_BIT] & lanes_on;
      end
    end
  end

  // Receive lane enable; gated exactly like the transmit side
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        rx_path_lane_enable_o[l] <= 1'b0;
      end else begin
        rx_path_lane_enable_o[l] <= drive_q[l][ls_lane_cfg_pkg::RX_EN_BIT] & lanes_on;
      end
    end
  end

  // Lane rates; stored values stay readable even while hardware chooses
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        tx_path_lane_rate_o[l] <= ls_lane_cfg_pkg::RATE_FULL;
        rx_path_lane_rate_o[l] <= ls_lane_cfg_pkg::RATE_FULL;
      end else begin
        tx_path_lane_rate_o[l] <= ls_lane_cfg_pkg::pick_rate(override,
          drive_q[l][ls_lane_cfg_pkg::TX_RATE_MSB:ls_lane_cfg_pkg::TX_RATE_LSB],
          auto_tx_rate_i[l]);
        rx_path_lane_rate_o[l] <= ls_lane_cfg_pkg::pick_rate(override,
          drive_q[l][ls_lane_cfg_pkg::RX_RATE_MSB:ls_lane_cfg_pkg::RX_RATE_LSB],
          auto_rx_rate_i[l]);
      end
    end
  end

  // Polarity swaps on the receive outputs and transmit inputs
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        rx_output_polarity_swap_o[l] <= ls_lane_cfg_pkg::RST_POL_EQ[ls_lane_cfg_pkg::RX_SWAP_BIT];
        tx_input_polarity_swap_o[l] <= ls_lane_cfg_pkg::RST_POL_EQ[ls_lane_cfg_pkg::TX_SWAP_BIT];
      end else begin
        rx_output_polarity_swap_o[l] <= poleq_q[l][ls_lane_cfg_pkg::RX_SWAP_BIT];
        tx_input_polarity_swap_o[l] <= poleq_q[l][ls_lane_cfg_pkg::TX_SWAP_BIT];
      end
    end
  end

  // Equalizer code; reserved codes are flagged, not blocked
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < ls_lane_cfg_pkg::NUM_LANES; l++) begin
      if (!rst_n_i) begin
        lane_equalizer_code_o[l] <=
          ls_lane_cfg_pkg::RST_POL_EQ[ls_lane_cfg_pkg::EQ_MSB:ls_lane_cfg_pkg::EQ_LSB];
        lane_equalizer_code_rsvd_o[l] <= 1'b0;
      end else begin
        lane_equalizer_code_o[l] <=
          poleq_q[l][ls_lane_cfg_pkg::EQ_MSB:ls_lane_cfg_pkg::EQ_LSB];
        lane_equalizer_code_rsvd_o[l] <=
          (poleq_q[l][ls_lane_cfg_pkg::EQ_MSB:ls_lane_cfg_pkg::EQ_LSB]
             >= ls_lane_cfg_pkg::EQ_RSVD_LO) &&
          (poleq_q[l][ls_lane_cfg_pkg::EQ_MSB:ls_lane_cfg_pkg::EQ_LSB]
             <= ls_lane_cfg_pkg::EQ_RSVD_HI);
      end
    end
  end

  // Multiplier: software code counts only under override
  assign mpy.code = override ? pll_multiplier_code_i : auto_pll_multiplier_code_i;

  pll_mpy_decode u_mpy_decode (
    .mpy(mpy.decoder)
  );

  // Registered multiplier result
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pll_multiplier_code_o <= 4'h0;
      pll_multiplier_factor_x2_o <= 8'h00;
      pll_multiplier_code_rsvd_o <= 1'b0;
    end else begin
      pll_multiplier_code_o <= mpy.code;
      pll_multiplier_factor_x2_o <= mpy.factor_x2;
      pll_multiplier_code_rsvd_o <= mpy.reserved;
    end
  end

endmodule // ls_serdes_lane_config_regs

`default_nettype wire

// ==== ls_lane_cfg_pkg.sv ====
// Constants and types for the per-lane low-speed serdes configuration bank
// Summary of operation
// - Multiplier code decodes to 4..65x; codes 0011,1011,1100,1111 are reserved
// - Drive/rate bits 14:12 are output amplitude select, reset 101
// - Drive/rate bit 11 enables signal-loss detection, reset 1
// - Bit 10 enables transmit lane, forced off by power-down pin or global bit
// - Bits 9:8 transmit rate: full, half, quarter, 11 reserved; reset full
// - Lane rates come from hardware unless the override select bit is set
// - Bits 7:4 de-emphasis code, sixteen steps, reset 0000
// - Bit 2 enables receive lane, forced off by power-down pin or global bit
// - Bits 1:0 receive rate: full, half, quarter, 11 reserved; reset full
// - Polarity/eq bit 15 swaps receive output legs, reset 0
// - Polarity/eq bit 14 inverts transmit input polarity, reset 0
// - Bits 11:8 equalizer code, reset 0000; 0010 to 0111 reserved
// - Low byte read-write reset 0x0d; registers reset 0x000d and 0xdc04
// - Writes update only lanes whose mask bit is set; mask resets all ones (the bank takes lane_config_write_mask_i as an input with no reset)
// - Reads return one lane only for a one-hot mask; otherwise undefined
// - Multiplier code is automatic unless the override select bit is set
`default_nettype none

package ls_lane_cfg_pkg;

  localparam int unsigned NUM_LANES = 4;

  // Register addresses on the management port
  localparam logic [15:0] ADDR_DRIVE_RATE = 16'h0007;
  localparam logic [15:0] ADDR_POL_EQ = 16'h0008;

  // Reset values
  localparam logic [15:0] RST_DRIVE_RATE = 16'hdc04;
  localparam logic [15:0] RST_POL_EQ = 16'h000d;
  localparam logic [3:0] RST_LANE_MASK = 4'hf;

  // Drive/rate field positions
  localparam int unsigned AMP_MSB = 14;
  localparam int unsigned AMP_LSB = 12;
  localparam int unsigned LOS_EN_BIT = 11;
  localparam int unsigned TX_EN_BIT = 10;
  localparam int unsigned TX_RATE_MSB = 9;
  localparam int unsigned TX_RATE_LSB = 8;
  localparam int unsigned DE_MSB = 7;
  localparam int unsigned DE_LSB = 4;
  localparam int unsigned RX_EN_BIT = 2;
  localparam int unsigned RX_RATE_MSB = 1;
  localparam int unsigned RX_RATE_LSB = 0;

  // Polarity/equalization field positions
  localparam int unsigned RX_SWAP_BIT = 15;
  localparam int unsigned TX_SWAP_BIT = 14;
  localparam int unsigned EQ_MSB = 11;
  localparam int unsigned EQ_LSB = 8;

  // Lane rate encodings
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;
  localparam logic [1:0] RATE_RESERVED = 2'h3;

  // Equalizer reserved code range
  localparam logic [3:0] EQ_RSVD_LO = 4'h2;
  localparam logic [3:0] EQ_RSVD_HI = 4'h7;

  // Multiplier factors in half steps, so 12.5x fits an integer
  localparam logic [7:0] MPY_X2_4 = 8'h08;
  localparam logic [7:0] MPY_X2_5 = 8'h0a;
  localparam logic [7:0] MPY_X2_6 = 8'h0c;
  localparam logic [7:0] MPY_X2_8 = 8'h10;
  localparam logic [7:0] MPY_X2_10 = 8'h14;
  localparam logic [7:0] MPY_X2_12 = 8'h18;
  localparam logic [7:0] MPY_X2_12P5 = 8'h19;
  localparam logic [7:0] MPY_X2_15 = 8'h1e;
  localparam logic [7:0] MPY_X2_20 = 8'h28;
  localparam logic [7:0] MPY_X2_25 = 8'h32;
  localparam logic [7:0] MPY_X2_50 = 8'h64;
  localparam logic [7:0] MPY_X2_65 = 8'h82;

  typedef logic [NUM_LANES-1:0][15:0] lane_words_t;

  // True when a mask names exactly one lane
  function automatic logic is_one_hot(input logic [3:0] m);
    return (m == 4'h1) || (m == 4'h2) || (m == 4'h4) || (m == 4'h8);
  endfunction

  // Index of the single set bit of a one-hot mask
  function automatic logic [1:0] one_hot_index(input logic [3:0] m);
    logic [1:0] idx;
    idx = 2'h0;
    if (m[1]) idx = 2'h1;
    if (m[2]) idx = 2'h2;
    if (m[3]) idx = 2'h3;
    return idx;
  endfunction

  // Effective lane rate: hardware value unless software overrides
  function automatic logic [1:0] pick_rate(input logic ovr, input logic [1:0] sw,
                                           input logic [1:0] hw);
    return ovr ? sw : hw;
  endfunction

endpackage : ls_lane_cfg_pkg

`default_nettype wire

// ==== pll_mpy_if.sv ====
// Carrier between the bank and the multiplier decoder
`default_nettype none

interface pll_mpy_if;
  logic [3:0] code;
  logic [7:0] factor_x2;
  logic reserved;

  modport requester (output code, input factor_x2, input reserved);
  modport decoder (input code, output factor_x2, output reserved);
endinterface : pll_mpy_if

`default_nettype wire

// ==== pll_mpy_decode.sv ====
// Multiplier code to factor decoder for the low-speed PLL
`default_nettype none

module pll_mpy_decode (
  pll_mpy_if.decoder mpy
);

  // Table decode; reserved codes report factor zero
  always_comb begin
    mpy.reserved = 1'b0;
    case (mpy.code)
      4'h0: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_4;
      4'h1: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_5;
      4'h2: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_6;
      4'h4: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_8;
      4'h5: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_10;
      4'h6: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_12;
      4'h7: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_12P5;
      4'h8: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_15;
      4'h9: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_20;
      4'ha: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_25;
      4'hd: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_50;
      4'he: mpy.factor_x2 = ls_lane_cfg_pkg::MPY_X2_65;
      default: begin
        mpy.factor_x2 = 8'h00;
        mpy.reserved = 1'b1;
      end
    endcase
  end

endmodule // pll_mpy_decode

`default_nettype wire

// ==== ls_lane_cfg_assertions.sv ====
// Port-level checker for the lane configuration register bank
`default_nettype none

module ls_lane_cfg_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // Controls
  input wire logic refclk_rate_select_bit_i,
  input wire logic [3:0] pll_multiplier_code_i,
  input wire logic [3:0] auto_pll_multiplier_code_i,
  input wire logic channel_power_down_n_i,
  input wire logic global_power_down_i,
  // Lane and PLL results
  input wire logic [3:0] tx_path_lane_enable_o,
  input wire logic [3:0] rx_path_lane_enable_o,
  input wire logic [3:0][3:0] lane_equalizer_code_o,
  input wire logic [3:0] lane_equalizer_code_rsvd_o,
  input wire logic [3:0] pll_multiplier_code_o,
  input wire logic [7:0] pll_multiplier_factor_x2_o,
  input wire logic pll_multiplier_code_rsvd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Out of reset for a full cycle; first edge still shows reset values
  logic up_q;
  always_ff @(posedge clk_i) up_q <= rst_n_i;

  property p_rd_valid; up_q && reg_rd_i |=> reg_rvalid_o; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_no_valid; !reg_rd_i |=> !reg_rvalid_o; endproperty
  a_no_valid: assert property (p_no_valid) else $error("stray read valid");
  property p_rd_hold; up_q && !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_tx_off;
    up_q && (!channel_power_down_n_i || global_power_down_i) |=> tx_path_lane_enable_o == 4'h0;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx lane on in power-down");
  property p_rx_off;
    up_q && (!channel_power_down_n_i || global_power_down_i) |=> rx_path_lane_enable_o == 4'h0;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx lane on in power-down");
  property p_mpy_sel;
    up_q |=> pll_multiplier_code_o == ($past(refclk_rate_select_bit_i) ?
      $past(pll_multiplier_code_i) : $past(auto_pll_multiplier_code_i));
  endproperty
  a_mpy_sel: assert property (p_mpy_sel) else $error("multiplier source wrong");
  property p_mpy_rsvd;
    pll_multiplier_code_rsvd_o == (pll_multiplier_code_o inside {4'h3, 4'hb, 4'hc, 4'hf});
  endproperty
  a_mpy_rsvd: assert property (p_mpy_rsvd) else $error("multiplier reserved flag");
  property p_mpy_top; pll_multiplier_code_o == 4'he |-> pll_multiplier_factor_x2_o == 8'h82;
  endproperty
  a_mpy_top: assert property (p_mpy_top) else $error("factor for top code");
  property p_eq_rsvd;
    lane_equalizer_code_rsvd_o[0] == (lane_equalizer_code_o[0] inside {[4'h2:4'h7]});
  endproperty
  a_eq_rsvd: assert property (p_eq_rsvd) else $error("equalizer reserved flag");

  // Main scenarios reached
  c_read: cover property (reg_rvalid_o);
  c_mpy_rsvd: cover property (pll_multiplier_code_rsvd_o);
  c_pd: cover property (up_q && !channel_power_down_n_i);
endmodule // ls_lane_cfg_assertions

bind ls_serdes_lane_config_regs ls_lane_cfg_assertions i_chk (.clk_i, .rst_n_i, .reg_rd_i,
  .reg_rdata_o, .reg_rvalid_o, .refclk_rate_select_bit_i, .pll_multiplier_code_i,
  .auto_pll_multiplier_code_i, .channel_power_down_n_i, .global_power_down_i,
  .tx_path_lane_enable_o, .rx_path_lane_enable_o, .lane_equalizer_code_o,
  .lane_equalizer_code_rsvd_o, .pll_multiplier_code_o, .pll_multiplier_factor_x2_o,
  .pll_multiplier_code_rsvd_o);

`default_nettype wire

// ==== ls_serdes_lane_config_regs_test.sv ====
// Self-checking bench for the lane configuration register bank
`default_nettype none

module ls_serdes_lane_config_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] mask = 4'hf;
  logic ovr = 1'b0;
  logic [3:0] sw_mpy = 4'h0;
  logic [7:0] atx = 8'h1b;
  logic [7:0] arx = 8'he4;
  logic [3:0] ampy = 4'h5;
  logic pd_n = 1'b1;
  logic gpd = 1'b0;
  logic [15:0] rdata, de, eq;
  logic rvalid, mpy_rsvd;
  logic [11:0] amp;
  logic [3:0] los, tx_en, rx_en, rxs, txs, eq_rsvd, mpy;
  logic [7:0] tx_rate, rx_rate, fx2;
  logic [7:0] x2 [16] = '{8'h08, 8'h0a, 8'h0c, 8'h00, 8'h10, 8'h14, 8'h18, 8'h19,
    8'h1e, 8'h28, 8'h32, 8'h00, 8'h00, 8'h64, 8'h82, 8'h00};
  int error_cnt = 0;
  int total_checks = 0;

  ls_serdes_lane_config_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .lane_config_write_mask_i(mask), .refclk_rate_select_bit_i(ovr),
    .pll_multiplier_code_i(sw_mpy), .auto_tx_rate_i(atx), .auto_rx_rate_i(arx),
    .auto_pll_multiplier_code_i(ampy), .channel_power_down_n_i(pd_n),
    .global_power_down_i(gpd), .lane_output_amplitude_sel_o(amp),
    .lane_signal_loss_detect_en_o(los), .tx_path_lane_enable_o(tx_en),
    .tx_path_lane_rate_o(tx_rate), .lane_deemphasis_code_o(de), .rx_path_lane_enable_o(rx_en),
    .rx_path_lane_rate_o(rx_rate), .rx_output_polarity_swap_o(rxs),
    .tx_input_polarity_swap_o(txs), .lane_equalizer_code_o(eq),
    .lane_equalizer_code_rsvd_o(eq_rsvd), .pll_multiplier_code_o(mpy),
    .pll_multiplier_factor_x2_o(fx2), .pll_multiplier_code_rsvd_o(mpy_rsvd));

  // 100 ns period
  always #50 clk_i = ~clk_i;

  // Compare and count
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // Wait n edges, then land 1 ns past the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Strobes drop and an edge passes, so back-to-back calls never retoggle in one step
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d, input logic [3:0] m);
    addr = a;
    wdata = d;
    mask = m;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [3:0] m, input logic [15:0] e);
    addr = a;
    mask = m;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    chk("rvalid", 16'(rvalid), 16'h0001);
    chk("rdata", rdata, e);
    step(1);
  endtask

  task automatic final_report();
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, far beyond the hundred or so cycles the tests need
  initial begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end

  // Test sequence
  initial begin
    step(16);
    rst_n_i = 1'b1;
    step(2);
    chk("amp", 16'(amp), 16'h0b6d);
    chk("los", 16'(los), 16'h000f);
    chk("en", 16'({tx_en, rx_en}), 16'h00ff);
    for (int l = 0; l < 4; l++) begin
      rd_reg(16'h0007, 4'(1 << l), 16'hdc04);
      rd_reg(16'h0008, 4'(1 << l), 16'h000d);
    end
    wr_reg(16'h0008, 16'hc3a5, 4'h3);
    wr_reg(16'h0008, 16'h1234, 4'h0);
    wr_reg(16'h0009, 16'h1234, 4'hf);
    rd_reg(16'h0009, 4'h1, 16'h0000);
    rd_reg(16'h0008, 4'h5, 16'h0000);
    for (int l = 0; l < 4; l++)
      rd_reg(16'h0008, 4'(1 << l), (l < 2) ? 16'hc3a5 : 16'h000d);
    chk("swap", 16'({rxs, txs}), 16'h0033);
    chk("eq", eq, 16'h0033);
    chk("eq_rsvd", 16'(eq_rsvd), 16'h0003);
    // Both sides of the upper edge of the reserved equalizer range
    wr_reg(16'h0008, 16'h0800, 4'h4);
    wr_reg(16'h0008, 16'h0700, 4'h8);
    chk("eq edge", eq, 16'h7833);
    chk("eq_rsvd edge", 16'(eq_rsvd), 16'h000b);
    wr_reg(16'h0007, 16'h06f1, 4'h8);
    rd_reg(16'h0007, 4'h8, 16'h06f1);
    chk("tx_rate auto", 16'(tx_rate), 16'(atx));
    chk("rx_rate auto", 16'(rx_rate), 16'(arx));
    ovr = 1'b1;
    step(1);
    chk("tx_rate", 16'(tx_rate), 16'h0080);
    chk("rx_rate", 16'(rx_rate), 16'h0040);
    chk("de", de, 16'hf000);
    chk("amp3", 16'(amp), 16'h016d);
    chk("los3", 16'(los), 16'h0007);
    chk("en3", 16'({tx_en, rx_en}), 16'h00f7);
    pd_n = 1'b0;
    step(1);
    chk("pd pin", 16'({tx_en, rx_en}), 16'h0000);
    pd_n = 1'b1;
    gpd = 1'b1;
    step(1);
    chk("pd global", 16'({tx_en, rx_en}), 16'h0000);
    gpd = 1'b0;
    // Every multiplier code through the software path
    for (int c = 0; c < 16; c++) begin
      sw_mpy = 4'(c);
      step(2);
      chk("factor", 16'(fx2), 16'(x2[c]));
      chk("mpy_rsvd", 16'(mpy_rsvd), 16'(x2[c] == 8'h00));
    end
    ovr = 1'b0;
    step(2);
    chk("mpy auto", 16'(mpy), 16'(ampy));
    chk("factor auto", 16'(fx2), 16'h0014);
    final_report();
  end
endmodule // ls_serdes_lane_config_regs_test

`default_nettype wire
